/* logic/edhfp_pkg.sv */
// What this block does
// - Receive mode: outgoing UES set if incoming UES high or region validity low.
// - Receive mode, field without incoming packet: all three outgoing UES flags set high.
// - Missing-packet flag raised per field lacking the packet, cleared otherwise.
// - Packet present only if header 000 3FF 3FF 1F4 sits at right position.
// - 24-bit errored-field counter adds one per outgoing packet with counted errors.
// - Sixteen host sensitivity bits select counted flags; low enables a flag.
// - Packet-checksum error sensitivity bit enables counting when high.
// - Counter mode: 00 normal, 01 clear, 10 auto clear on read, 11 hold.
// - Clear mode zeroes counter, resumes counting, mode returns to 00.
// - Auto mode clears counter whenever host reads low count byte at 17.
// - Hold mode forces counter to zero until another mode is chosen.
// - Direction input low: flag lines are inputs, groups written by select.
// - Port-written flags go into next outgoing packet only, then normal.
// - Port-written flags override host overwrite values for that packet.
// - Select 00/01/10 map FF/AP/ANC flags; 11 carries source, PICTURE_VALIDITY_BIT, FIELD_VALIDITY_BIT.
// - Read-source bit latched, cleared at reset; high reads incoming flags.
// - Direction high drives lines; select 11 gives checksum, PICTURE_VALIDITY_BIT, FIELD_VALIDITY_BIT, S.
// - At select 11 checksum valid with source low, validity with source high.
// - Write starts on high-to-low; first low sample releases lines, then latch.
// - A write at one select changes only that group.
// - Direction sampled high: latch select, drive invalid, data one clock later.
// - Receive mode expects packet; transmit mode inserts fresh flags uncompared.
`default_nettype none

package edhfp_pkg;

  localparam int unsigned FLAG_W = 15;
  localparam int unsigned GROUP_W = 5;
  localparam int unsigned UES_POS = 4;
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned SENS_W = 16;
  localparam int unsigned SENS_CHKSM_POS = 15;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'h11;
  localparam logic [9:0] HDR_WORD0 = 10'h000;
  localparam logic [9:0] HDR_WORD1 = 10'h3FF;
  localparam logic [9:0] HDR_WORD2 = 10'h3FF;
  localparam logic [9:0] HDR_WORD3 = 10'h1F4;
  localparam logic [1:0] SEL_FF = 2'h0;
  localparam logic [1:0] SEL_AP = 2'h1;
  localparam logic [1:0] SEL_ANC = 2'h2;
  localparam logic [1:0] SEL_MISC = 2'h3;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CLEAR = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  localparam logic [1:0] MODE_HOLD = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic READ_SOURCE_RESET = 1'b0;

endpackage : edhfp_pkg

`default_nettype wire

/* logic/edhfp_missing_detect.sv */
`timescale 1ns/1ps
`default_nettype none

module edhfp_missing_detect
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Incoming ancillary words
  input wire logic [9:0] i_word,
  input wire logic i_word_valid,
  input wire logic i_hdr_slot,
  input wire logic i_field_start,
  input wire logic i_field_end,
  // Result
  output logic o_packet_missing_flag
);

  logic [9:0] hist0;
  logic [9:0] hist1;
  logic [9:0] hist2;
  logic found;
  logic hdr_match;

  ////////////////////////////////////////////////////////////////////////////////

  // The last three words are kept so the fourth completes the header check.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hist0 <= 10'h000;
      hist1 <= 10'h000;
      hist2 <= 10'h000;
    end
    else if (i_word_valid)
    begin
      hist2 <= hist1;
      hist1 <= hist0;
      hist0 <= i_word;
    end
  end

  assign hdr_match = (hist2 == edhfp_pkg::HDR_WORD0) && (hist1 == edhfp_pkg::HDR_WORD1) &&
                     (hist0 == edhfp_pkg::HDR_WORD2) && (i_word == edhfp_pkg::HDR_WORD3);

  // A header outside the expected slot is not counted as a packet.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      found <= 1'b0;
    else if (i_word_valid && i_hdr_slot && hdr_match)
      found <= 1'b1;
    else if (i_field_start)
      found <= 1'b0;
  end

  // Judged afresh every field, so only fields without a packet show it.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_packet_missing_flag <= 1'b0;
    else if (i_field_end)
      o_packet_missing_flag <= !found;
  end

endmodule : edhfp_missing_detect

`default_nettype wire

/* logic/edhfp_error_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module edhfp_error_counter #(
  parameter int unsigned COUNT_W = edhfp_pkg::COUNT_W
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Outgoing packet event
  input wire logic i_pkt_out,
  input wire logic [edhfp_pkg::FLAG_W-1:0] i_out_flags,
  input wire logic i_out_chksm_err,
  input wire logic [edhfp_pkg::SENS_W-1:0] i_sensitivity,
  // Host control
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode_wdata,
  input wire logic i_host_rd,
  input wire logic [7:0] i_host_addr,
  // State
  output logic [1:0] o_counter_mode_field,
  output logic [COUNT_W-1:0] o_count
);

  logic hit;
  logic low_read;

  ////////////////////////////////////////////////////////////////////////////////

  // Flag sensitivities are active low, checksum sensitivity active high.
  assign hit = |(i_out_flags & ~i_sensitivity[edhfp_pkg::FLAG_W-1:0]) ||
               (i_out_chksm_err && i_sensitivity[edhfp_pkg::SENS_CHKSM_POS]);
  assign low_read = i_host_rd && (i_host_addr == edhfp_pkg::COUNT_LOW_ADDR);

  // Clear mode falls back to normal after the one clearing cycle.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_counter_mode_field <= edhfp_pkg::MODE_RESET;
    else if (i_mode_wr)
      o_counter_mode_field <= i_mode_wdata;
    else if (o_counter_mode_field == edhfp_pkg::MODE_CLEAR)
      o_counter_mode_field <= edhfp_pkg::MODE_NORMAL;
  end

  // An error in the same cycle as an auto clear starts the new count at one.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_count <= '0;
    else
    begin
      unique case (o_counter_mode_field)
        edhfp_pkg::MODE_NORMAL:
          if (i_pkt_out && hit)
            o_count <= o_count + 1'b1;
        edhfp_pkg::MODE_CLEAR:
          o_count <= '0;
        edhfp_pkg::MODE_AUTO:
          if (low_read)
            o_count <= COUNT_W'(i_pkt_out && hit);
          else if (i_pkt_out && hit)
            o_count <= o_count + 1'b1;
        edhfp_pkg::MODE_HOLD:
          o_count <= '0;
      endcase
    end
  end

endmodule : edhfp_error_counter

`default_nettype wire

/* logic/edhfp_top.sv */
`timescale 1ns/1ps
`default_nettype none

module edhfp_top #(
  parameter int unsigned COUNT_W = edhfp_pkg::COUNT_W
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Mode
  input wire logic i_rx_mode,
  // Incoming stream for packet detection
  input wire logic [9:0] i_word,
  input wire logic i_word_valid,
  input wire logic i_hdr_slot,
  input wire logic i_field_start,
  input wire logic i_field_end,
  // Incoming packet contents
  input wire logic i_in_pkt,
  input wire logic [edhfp_pkg::FLAG_W-1:0] i_in_flags,
  input wire logic i_in_picture_validity_bit,
  input wire logic i_in_field_validity_bit,
  input wire logic i_in_chksm_err,
  input wire logic [edhfp_pkg::FLAG_W-1:0] i_calc_flags,
  input wire logic i_s_bit,
  // Outgoing packet strobe
  input wire logic i_pkt_out,
  // Host port
  input wire logic [edhfp_pkg::FLAG_W-1:0] i_host_ow_values,
  input wire logic [edhfp_pkg::FLAG_W-1:0] i_host_ow_control,
  input wire logic [edhfp_pkg::SENS_W-1:0] i_sensitivity,
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode_wdata,
  input wire logic i_host_rd,
  input wire logic [7:0] i_host_addr,
  output logic [7:0] o_host_rdata,
  // Flag port
  input wire logic i_flag_dir,
  input wire logic [1:0] i_flag_sel,
  input wire logic [4:0] i_flag_lines,
  output logic [4:0] o_flag_lines,
  output logic o_flag_lines_oe_n,
  // Status
  output logic [edhfp_pkg::FLAG_W-1:0] o_out_flags,
  output logic o_out_picture_validity_bit,
  output logic o_out_field_validity_bit,
  output logic o_packet_missing_flag,
  output logic [1:0] o_counter_mode_field,
  output logic [COUNT_W-1:0] o_count
);

  localparam int unsigned NGRP = 3;

  logic rst_meta_n;
  logic rst_n;
  logic [edhfp_pkg::FLAG_W-1:0] in_flags;
  logic in_apv;
  logic in_ffv;
  logic chksm_err;
  logic [edhfp_pkg::FLAG_W-1:0] next_out_flags;
  logic [edhfp_pkg::FLAG_W-1:0] port_flags;
  logic [NGRP-1:0] port_pending;
  logic [NGRP-1:0] port_wr;
  logic port_apv;
  logic port_ffv;
  logic port_val_pending;
  logic read_source;
  logic dir_q;
  logic [1:0] sel_q;
  logic wr_take;
  logic [4:0] read_word;
  logic [edhfp_pkg::FLAG_W-1:0] read_flags;

  ////////////////////////////////////////////////////////////////////////////////

  // Reset is applied at once but released only after two clocks.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  edhfp_missing_detect u_missing
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_word(i_word),
    .i_word_valid(i_word_valid),
    .i_hdr_slot(i_hdr_slot),
    .i_field_start(i_field_start),
    .i_field_end(i_field_end),
    .o_packet_missing_flag(o_packet_missing_flag)
  );

  edhfp_error_counter #(
    .COUNT_W(COUNT_W)
  ) u_counter
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_pkt_out(i_pkt_out),
    .i_out_flags(next_out_flags),
    .i_out_chksm_err(chksm_err),
    .i_sensitivity(i_sensitivity),
    .i_mode_wr(i_mode_wr),
    .i_mode_wdata(i_mode_wdata),
    .i_host_rd(i_host_rd),
    .i_host_addr(i_host_addr),
    .o_counter_mode_field(o_counter_mode_field),
    .o_count(o_count)
  );

  // Only the low count byte is mapped; other addresses read zero.
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      o_host_rdata <= 8'h00;
    else if (i_host_rd)
      o_host_rdata <= (i_host_addr == edhfp_pkg::COUNT_LOW_ADDR) ? o_count[7:0] : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Incoming packet contents are held so the flag port can read them later.
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_flags <= '0;
      in_apv <= 1'b1;
      in_ffv <= 1'b1;
      chksm_err <= 1'b0;
    end
    else if (i_in_pkt)
    begin
      in_flags <= i_in_flags;
      in_apv <= i_in_picture_validity_bit;
      in_ffv <= i_in_field_validity_bit;
      chksm_err <= i_in_chksm_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Per group: base flags, then host overwrite, then one-shot port values.
  for (genvar g = 0; g < NGRP; g++)
  begin : g_grp
    localparam int unsigned LO = g * edhfp_pkg::GROUP_W;
    localparam int unsigned UB = LO + edhfp_pkg::UES_POS;
    logic [edhfp_pkg::GROUP_W-1:0] base;
    logic [edhfp_pkg::GROUP_W-1:0] hosted;
    logic invalid;

    // Only FF and AP carry validity bits; ANC never does.
    if (g == 0)
    begin : g_ff
      assign invalid = !in_ffv;
    end
    else if (g == 1)
    begin : g_ap
      assign invalid = !in_apv;
    end
    else
    begin : g_anc
      assign invalid = 1'b0;
    end

    always_comb
    begin
      base = '0;
      if (i_rx_mode)
      begin
        base = i_calc_flags[LO +: edhfp_pkg::GROUP_W];
        if (o_packet_missing_flag)
          base[edhfp_pkg::UES_POS] = 1'b1;
        else
          base[edhfp_pkg::UES_POS] = in_flags[UB] | invalid;
      end
      hosted = (base & ~i_host_ow_control[LO +: edhfp_pkg::GROUP_W]) |
               (i_host_ow_values[LO +: edhfp_pkg::GROUP_W] &
                i_host_ow_control[LO +: edhfp_pkg::GROUP_W]);
      next_out_flags[LO +: edhfp_pkg::GROUP_W] =
        port_pending[g] ? port_flags[LO +: edhfp_pkg::GROUP_W] : hosted;
    end

    assign port_wr[g] = wr_take && (i_flag_sel == 2'(g));

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        port_flags[LO +: edhfp_pkg::GROUP_W] <= '0;
      else if (port_wr[g])
        port_flags[LO +: edhfp_pkg::GROUP_W] <= i_flag_lines;
    end

    // A new write wins over the clear made by the packet it coincides with.
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        port_pending[g] <= 1'b0;
      else if (port_wr[g])
        port_pending[g] <= 1'b1;
      else if (i_pkt_out)
        port_pending[g] <= 1'b0;
    end
  end

  // Outgoing flags are registered when the outgoing packet is built.
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_out_flags <= '0;
      o_out_picture_validity_bit <= 1'b1;
      o_out_field_validity_bit <= 1'b1;
    end
    else if (i_pkt_out)
    begin
      o_out_flags <= next_out_flags;
      o_out_picture_validity_bit <= port_val_pending ? port_apv : 1'b1;
      o_out_field_validity_bit <= port_val_pending ? port_ffv : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Writes are taken only once the first low sample has released the lines.
  assign wr_take = !i_flag_dir && !dir_q;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_q <= 1'b1;
      sel_q <= 2'h0;
    end
    else
    begin
      dir_q <= i_flag_dir;
      sel_q <= i_flag_sel;
    end
  end

  // Select 11 writes the read source and the outgoing validity bits.
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_source <= edhfp_pkg::READ_SOURCE_RESET;
      port_apv <= 1'b1;
      port_ffv <= 1'b1;
    end
    else if (wr_take && i_flag_sel == edhfp_pkg::SEL_MISC)
    begin
      read_source <= i_flag_lines[4];
      port_apv <= i_flag_lines[3];
      port_ffv <= i_flag_lines[2];
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      port_val_pending <= 1'b0;
    else if (wr_take && i_flag_sel == edhfp_pkg::SEL_MISC)
      port_val_pending <= 1'b1;
    else if (i_pkt_out)
      port_val_pending <= 1'b0;
  end

  // The read source steers reads only; writes never look at it.
  assign read_flags = read_source ? in_flags : o_out_flags;

  // Validity always comes from the incoming packet, so it is only meaningful
  // with the source high; the checksum error is meaningful with it low.
  always_comb
  begin
    unique case (sel_q)
      edhfp_pkg::SEL_FF:
        read_word = read_flags[0 +: edhfp_pkg::GROUP_W];
      edhfp_pkg::SEL_AP:
        read_word = read_flags[edhfp_pkg::GROUP_W +: edhfp_pkg::GROUP_W];
      edhfp_pkg::SEL_ANC:
        read_word = read_flags[2 * edhfp_pkg::GROUP_W +: edhfp_pkg::GROUP_W];
      edhfp_pkg::SEL_MISC:
        read_word = {chksm_err, in_apv, in_ffv, i_s_bit, 1'b0};
    endcase
  end

  // Lines are released on the first low sample and driven on a high one.
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      o_flag_lines_oe_n <= 1'b1;
    else
      o_flag_lines_oe_n <= !i_flag_dir;
  end

  // The first driven cycle after a write carries don't-care zeros.
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      o_flag_lines <= 5'h00;
    else if (i_flag_dir && dir_q)
      o_flag_lines <= read_word;
    else
      o_flag_lines <= 5'h00;
  end

endmodule : edhfp_top

`default_nettype wire

/* verif/edhfp_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module edhfp_top_monitor #(
  parameter int unsigned COUNT_W = edhfp_pkg::COUNT_W
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Stimulus seen at the top
  input wire logic i_flag_dir,
  input wire logic i_pkt_out,
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode_wdata,
  input wire logic i_host_rd,
  input wire logic [7:0] i_host_addr,
  // Outputs of the top
  input wire logic [4:0] o_flag_lines,
  input wire logic o_flag_lines_oe_n,
  input wire logic [7:0] o_host_rdata,
  input wire logic [edhfp_pkg::FLAG_W-1:0] o_out_flags,
  input wire logic [1:0] o_counter_mode_field,
  input wire logic [COUNT_W-1:0] o_count
);
  // The design holds its own reset for two edges after release, so checks wait.
  logic [1:0] up;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn || up != 2'h3);

  sequence seq_read_start;
    !i_flag_dir ##1 i_flag_dir;
  endsequence

  sequence seq_clear_done;
    o_counter_mode_field == edhfp_pkg::MODE_CLEAR
      ##1 (o_count == '0 && o_counter_mode_field == edhfp_pkg::MODE_NORMAL);
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  chk_oe_read: assert property (
    i_flag_dir |=> !o_flag_lines_oe_n) else $error("flag lines not driven in read");
  chk_oe_write: assert property (
    !i_flag_dir |=> o_flag_lines_oe_n) else $error("flag lines driven in write");
  chk_read_invalid: assert property (
    seq_read_start |=> o_flag_lines == 5'h00) else $error("first read cycle not blank");
  chk_count_step: assert property (
    o_count != $past(o_count) && !$past(i_host_rd)
      |-> o_count == '0 || o_count == COUNT_W'($past(o_count) + 1'b1))
    else $error("counter moved by more than one");
  chk_count_cause: assert property (
    o_count != $past(o_count) && o_count != '0 |-> $past(i_pkt_out))
    else $error("counter moved without outgoing packet");
  chk_mode_clear: assert property (
    i_mode_wr && i_mode_wdata == edhfp_pkg::MODE_CLEAR |=> seq_clear_done)
    else $error("clear mode did not zero and return");
  chk_hold_zero: assert property (
    o_counter_mode_field == edhfp_pkg::MODE_HOLD && !i_mode_wr |=> o_count == '0)
    else $error("hold mode let counter move");
  chk_auto_clear: assert property (
    i_host_rd && i_host_addr == edhfp_pkg::COUNT_LOW_ADDR && !i_pkt_out && !i_mode_wr
      && o_counter_mode_field == edhfp_pkg::MODE_AUTO
      |=> o_count == '0 && o_host_rdata == $past(o_count[7:0]))
    else $error("auto clear on read failed");
  chk_unmapped_zero: assert property (
    i_host_rd && i_host_addr != edhfp_pkg::COUNT_LOW_ADDR |=> o_host_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_flags_when: assert property (
    o_out_flags != $past(o_out_flags) |-> $past(i_pkt_out))
    else $error("outgoing flags changed without packet");

endmodule : edhfp_top_monitor

bind edhfp_top edhfp_top_monitor #(.COUNT_W(COUNT_W)) edhfp_top_monitor_inst (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_flag_dir(i_flag_dir),
  .i_pkt_out(i_pkt_out), .i_mode_wr(i_mode_wr), .i_mode_wdata(i_mode_wdata),
  .i_host_rd(i_host_rd), .i_host_addr(i_host_addr), .o_flag_lines(o_flag_lines),
  .o_flag_lines_oe_n(o_flag_lines_oe_n), .o_host_rdata(o_host_rdata),
  .o_out_flags(o_out_flags), .o_counter_mode_field(o_counter_mode_field),
  .o_count(o_count));

`default_nettype wire

/* verif/edhfp_flag_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module edhfp_flag_ctrl
(
  // Clock
  input wire logic i_clk_sys,
  // Device side of the flag lines
  input wire logic [4:0] i_dev_lines,
  input wire logic i_dev_oe_n,
  // Controller side
  output logic o_dir,
  output logic [1:0] o_sel,
  output logic [4:0] o_wire
);
  logic drive = 1'b0;
  logic [4:0] drv = 5'h00;
  logic [4:0] last = 5'h00;

  initial
  begin
    o_dir = 1'b1;
    o_sel = 2'h0;
  end

  // A released bus shows the inverse of its last level, so stale data never passes.
  always_comb
  begin
    if (!i_dev_oe_n)
      o_wire = i_dev_lines;
    else if (drive)
      o_wire = drv;
    else
      o_wire = ~last;
  end

  always_ff @(posedge i_clk_sys)
    last <= o_wire;

  task automatic wr2(input logic [1:0] s0, input logic [4:0] v0,
                     input logic [1:0] s1, input logic [4:0] v1);
    o_dir = 1'b0;
    o_sel = s0;
    @(posedge i_clk_sys) #1;
    drive = 1'b1;
    drv = v0;
    @(posedge i_clk_sys) #1;
    o_sel = s1;
    drv = v1;
    @(posedge i_clk_sys) #1;
    drive = 1'b0;
    o_dir = 1'b1;
  endtask : wr2

  task automatic rd(input logic [1:0] s, output logic [4:0] v);
    o_sel = s;
    @(posedge i_clk_sys) #1;
    @(posedge i_clk_sys) #1;
    v = o_wire;
  endtask : rd

endmodule : edhfp_flag_ctrl

`default_nettype wire

/* verif/edhfp_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module edhfp_top_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rx = 1'b0;
  logic [9:0] word = 10'h000;
  logic wval = 1'b0;
  logic slot = 1'b0;
  logic fstart = 1'b0;
  logic fend = 1'b0;
  logic in_pkt = 1'b0;
  logic [14:0] in_fl = 15'h0000;
  logic in_apv = 1'b1;
  logic in_ffv = 1'b1;
  logic in_ck = 1'b0;
  logic s_bit = 1'b1;
  logic pkt = 1'b0;
  logic [14:0] ow_v = 15'h0000;
  logic [14:0] ow_c = 15'h0000;
  logic [15:0] sens = 16'h7FFF;
  logic mwr = 1'b0;
  logic [1:0] mwd = 2'h0;
  logic hrd = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [7:0] hrdata;
  logic dir;
  logic [1:0] sel;
  logic [4:0] fl_wire;
  logic [4:0] dev_fl;
  logic oe_n;
  logic [14:0] out_fl;
  logic out_apv;
  logic out_ffv;
  logic miss;
  logic [1:0] mode;
  logic [23:0] count;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  edhfp_top edhfp_top_inst (
    .i_clk_sys(clk), .i_rstn(rstn), .i_rx_mode(rx), .i_word(word), .i_word_valid(wval),
    .i_hdr_slot(slot), .i_field_start(fstart), .i_field_end(fend), .i_in_pkt(in_pkt),
    .i_in_flags(in_fl), .i_in_picture_validity_bit(in_apv),
    .i_in_field_validity_bit(in_ffv), .i_in_chksm_err(in_ck), .i_calc_flags(15'h0000),
    .i_s_bit(s_bit), .i_pkt_out(pkt), .i_host_ow_values(ow_v), .i_host_ow_control(ow_c),
    .i_sensitivity(sens), .i_mode_wr(mwr), .i_mode_wdata(mwd), .i_host_rd(hrd),
    .i_host_addr(haddr), .o_host_rdata(hrdata), .i_flag_dir(dir), .i_flag_sel(sel),
    .i_flag_lines(fl_wire), .o_flag_lines(dev_fl), .o_flag_lines_oe_n(oe_n),
    .o_out_flags(out_fl), .o_out_picture_validity_bit(out_apv),
    .o_out_field_validity_bit(out_ffv), .o_packet_missing_flag(miss),
    .o_counter_mode_field(mode), .o_count(count));

  edhfp_flag_ctrl edhfp_flag_ctrl_inst (
    .i_clk_sys(clk), .i_dev_lines(dev_fl), .i_dev_oe_n(oe_n), .o_dir(dir), .o_sel(sel),
    .o_wire(fl_wire));

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // Wide enough for the packed groups of fields that some checks compare at once.
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // The idle edge keeps a following call from raising the strobe in the same step.
  task automatic pkt_out();
    pkt = 1'b1;
    tick(1);
    pkt = 1'b0;
    tick(1);
  endtask : pkt_out

  task automatic set_mode(input logic [1:0] m);
    mwr = 1'b1;
    mwd = m;
    tick(1);
    mwr = 1'b0;
  endtask : set_mode

  task automatic host_rd(input logic [7:0] a, output logic [7:0] d);
    hrd = 1'b1;
    haddr = a;
    tick(1);
    hrd = 1'b0;
    d = hrdata;
    tick(1);
  endtask : host_rd

  task automatic field(input logic [9:0] w3, input logic at_slot);
    logic [9:0] hdr [4];
    hdr = '{edhfp_pkg::HDR_WORD0, edhfp_pkg::HDR_WORD1, edhfp_pkg::HDR_WORD2, w3};
    fstart = 1'b1;
    tick(1);
    fstart = 1'b0;
    wval = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      word = hdr[k];
      slot = (k == 3) && at_slot;
      tick(1);
    end
    wval = 1'b0;
    slot = 1'b0;
    fend = 1'b1;
    tick(1);
    fend = 1'b0;
    check("missing", miss, !(at_slot && w3 == edhfp_pkg::HDR_WORD3));
  endtask : field

  // A hang is cut short well beyond the hundred or so cycles the tests need.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [4:0] v;
    logic [7:0] d;
    tick(3);
    check("oe_n_rst", oe_n, 1'b1);
    check("count_rst", count, 24'h0);
    rstn = 1'b1;
    tick(3);
    rx = 1'b1;
    field(edhfp_pkg::HDR_WORD3, 1'b1);
    field(edhfp_pkg::HDR_WORD3, 1'b0);
    field(10'h1F5, 1'b1);
    pkt_out();
    check("ues_nopkt", out_fl, 15'h4210);
    field(edhfp_pkg::HDR_WORD3, 1'b1);
    in_fl = 15'h0D51;
    in_apv = 1'b0;
    in_ck = 1'b1;
    in_pkt = 1'b1;
    tick(1);
    in_pkt = 1'b0;
    pkt_out();
    check("ues_rx", out_fl, 15'h0210);
    $display("test packet detect done");
    rx = 1'b0;
    ow_c = 15'h0001;
    ow_v = 15'h0001;
    sens = 16'h7FFE;
    for (int k = 1; k <= 3; k++)
    begin
      pkt_out();
      check("count", count, k);
    end
    sens = 16'h7FFF;
    pkt_out();
    check("count_masked", count, 24'h3);
    sens = 16'hFFFF;
    pkt_out();
    check("count_chksm", count, 24'h4);
    host_rd(edhfp_pkg::COUNT_LOW_ADDR, d);
    check("rd_low", {d, count}, {8'h04, 24'h4});
    host_rd(8'h12, d);
    check("rd_unmapped", d, 8'h00);
    set_mode(edhfp_pkg::MODE_AUTO);
    pkt_out();
    host_rd(edhfp_pkg::COUNT_LOW_ADDR, d);
    check("rd_auto", {d, count, mode}, {8'h05, 24'h0, edhfp_pkg::MODE_AUTO});
    pkt_out();
    check("count_resume", count, 24'h1);
    set_mode(edhfp_pkg::MODE_CLEAR);
    tick(1);
    check("clr", {mode, count}, {edhfp_pkg::MODE_NORMAL, 24'h0});
    pkt_out();
    check("count_clr_go", count, 24'h1);
    set_mode(edhfp_pkg::MODE_HOLD);
    pkt_out();
    check("hold", {mode, count}, {edhfp_pkg::MODE_HOLD, 24'h0});
    set_mode(edhfp_pkg::MODE_NORMAL);
    pkt_out();
    check("count_free", count, 24'h1);
    sens = 16'h7FFF;
    $display("test counter done");
    edhfp_flag_ctrl_inst.rd(edhfp_pkg::SEL_FF, v);
    check("rd_out_ff", v, 5'h01);
    edhfp_flag_ctrl_inst.wr2(edhfp_pkg::SEL_FF, 5'h14, edhfp_pkg::SEL_ANC, 5'h0A);
    pkt_out();
    check("port_flags", out_fl, 15'h2814);
    pkt_out();
    check("normal_flags", out_fl, 15'h0001);
    edhfp_flag_ctrl_inst.wr2(edhfp_pkg::SEL_MISC, 5'h04, edhfp_pkg::SEL_MISC, 5'h04);
    pkt_out();
    check("port_valid", {out_apv, out_ffv, out_fl}, {2'b01, 15'h0001});
    pkt_out();
    check("valid_back", {out_apv, out_ffv}, 2'b11);
    edhfp_flag_ctrl_inst.rd(edhfp_pkg::SEL_MISC, v);
    check("rd_chksm", {v[4], v[1]}, 2'b11);
    edhfp_flag_ctrl_inst.wr2(edhfp_pkg::SEL_MISC, 5'h1C, edhfp_pkg::SEL_MISC, 5'h1C);
    edhfp_flag_ctrl_inst.rd(edhfp_pkg::SEL_AP, v);
    check("rd_in_ap", v, 5'h0A);
    s_bit = 1'b0;
    edhfp_flag_ctrl_inst.rd(edhfp_pkg::SEL_MISC, v);
    check("rd_valid", v[3:1], 3'b010);
    $display("test flag port done");
    stop_test();
  end

endmodule : edhfp_top_tb_top

`default_nettype wire
